// ### src/smrc_pkg.sv
package smrc_pkg;

  // timing: release delay after a reset source goes away
  localparam int CLK_MHZ        = 200;
  localparam int RELEASE_US     = 100;
  localparam int RELEASE_CYCLES = RELEASE_US * CLK_MHZ;
  localparam int CNT_W          = 20;

  // word offsets on the register bus
  localparam logic [3:0] OFS_CAUSE_A  = 4'h0;
  localparam logic [3:0] OFS_CAUSE_B  = 4'h1;
  localparam logic [3:0] OFS_CAUSE_C  = 4'h2;
  localparam logic [3:0] OFS_SWRESET  = 4'h3;
  localparam logic [3:0] OFS_LEVEL    = 4'h4;
  localparam logic [3:0] OFS_CMPCTL   = 4'h5;
  localparam logic [3:0] OFS_M1_CR0   = 4'h6;
  localparam logic [3:0] OFS_M1_CR1   = 4'h7;
  localparam logic [3:0] OFS_M1_SR    = 4'h8;
  localparam logic [3:0] OFS_M2_CR0   = 4'h9;
  localparam logic [3:0] OFS_M2_CR1   = 4'hA;
  localparam logic [3:0] OFS_M2_SR    = 4'hB;
  localparam logic [3:0] OFS_IRQ_STAT = 4'hC;
  localparam logic [3:0] OFS_IRQ_CLR  = 4'hD;
  localparam logic [3:0] OFS_IRQ_EN   = 4'hE;

  // field positions
  localparam int CA_POR   = 0;
  localparam int CA_M0    = 1;
  localparam int CA_M1    = 2;
  localparam int CA_M2    = 3;
  localparam int CB_CWS   = 0;
  localparam int CC_WDT   = 0;
  localparam int CC_SW    = 1;
  localparam int LVL1_LSB = 0;
  localparam int LVL2_LSB = 4;
  localparam int SR_CHG   = 0;
  localparam int SR_STATE = 1;

  // reset values and monitor 1 level count
  localparam logic [3:0] CAUSE_A_RST = 4'h1;
  localparam logic [3:0] LVL1_RST    = 4'h0;
  localparam logic [1:0] LVL2_RST    = 2'h0;
  localparam logic [3:0] MON1_LEVELS = 4'h9;

  // interrupt condition encodings; 3 behaves as both
  localparam logic [1:0] COND_BOTH = 2'h0;
  localparam logic [1:0] COND_FALL = 2'h1;
  localparam logic [1:0] COND_RISE = 2'h2;

  typedef struct packed {
    logic release_select;
    logic reset_or_irq;
    logic compare_enable;
    logic action_enable;
  } smrc_cr0_t;

  typedef struct packed {
    logic       irq_type;
    logic [1:0] irq_condition;
  } smrc_cr1_t;

endpackage

// ### src/smrc_top.sv
`timescale 1ns/10ps
// How it works
// - monitor 0 holds reset while supply low, releases a fixed delay after recovery
// - monitor 0 level comes from a two-bit option strap
// - monitor 1 level is a four-bit field with nine legal values
// - monitor 2 level is a two-bit field, four levels
// - monitors 1 and 2 show live above/below state flags
// - monitors 1 and 2 flag every threshold crossing, either direction
// - reset mode: reset on drop, release after recovery or after drop
// - type bit routes a monitor interrupt to nmi or maskable interrupt
// - condition field picks falling, rising or both crossings
// - mode bit picks reset or interrupt for a detection
// - action enable gates the interrupt or reset of a monitor
// - compare enable gates the comparator into monitor logic
// - detector enables in a shared register; disabled gives no detection
// - power-on reset sets the power-on cause flag
// - separate cause flags for power-on and monitors 0, 1, 2
// - cold/warm flag tells cold power-up from warm restart
// - writing the software reset register resets chip, sets its flag
// - watchdog underflow or refresh error resets chip, sets its flag
module smrc_top
  import smrc_pkg::*;
#(
  parameter int RELEASE_COUNT = RELEASE_CYCLES
) (
  // clock and power-on reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // register bus
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // comparators and reset sources
  input  wire logic [1:0]  monitor0_level_select,
  input  wire logic        monitor0_below,
  input  wire logic [1:0]  monitor_below,
  input  wire logic        watchdog_underflow,
  input  wire logic        watchdog_refresh_error,
  // levels to the comparators
  output logic      [1:0]  monitor0_level,
  output logic      [3:0]  monitor1_level_select,
  output logic      [1:0]  monitor2_level_select,
  // reset and interrupts
  output logic             chip_reset,
  output logic             nmi_req,
  output logic             irq
);

  if (RELEASE_COUNT < 1 || RELEASE_COUNT >= 2**CNT_W) begin : g_bad_count
    $error("RELEASE_COUNT out of range");
  end

  // bus slave: one wait cycle on every access
  logic        ack_r;
  logic [31:0] readdata_r;
  wire         bus_acc = avs_read | avs_write;
  wire         wr_en   = avs_write & ack_r;
  wire         rd_go   = avs_read & ~ack_r;
  wire  [31:0] rmap [16];
  assign avs_waitrequest = bus_acc & ~ack_r;
  assign avs_readdata    = readdata_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_r      <= 1'b0;
      readdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= bus_acc & ~ack_r;
      if (rd_go) begin
        readdata_r <= rmap[avs_address];
      end
    end
  end

  wire wr_cause_a = wr_en && avs_address == OFS_CAUSE_A;
  wire wr_cause_b = wr_en && avs_address == OFS_CAUSE_B;
  wire wr_cause_c = wr_en && avs_address == OFS_CAUSE_C;
  wire wr_swreset = wr_en && avs_address == OFS_SWRESET;
  wire wr_level   = wr_en && avs_address == OFS_LEVEL;
  wire wr_cmpctl  = wr_en && avs_address == OFS_CMPCTL;
  wire wr_irq_clr = wr_en && avs_address == OFS_IRQ_CLR;
  wire wr_irq_en  = wr_en && avs_address == OFS_IRQ_EN;

  // monitor 0 level is a strap, caught once after reset release
  logic [1:0] m0_lvl_r;
  logic       strap_done_r;
  assign monitor0_level = m0_lvl_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      m0_lvl_r     <= 2'h0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      m0_lvl_r     <= monitor0_level_select;
      strap_done_r <= 1'b1;
    end
  end

  // level and comparator control registers
  logic [3:0] lvl1_r;
  logic [1:0] lvl2_r;
  logic [1:0] det_en_r;
  wire  [3:0] lvl1_wd = avs_writedata[LVL1_LSB +: 4];
  assign monitor1_level_select = lvl1_r;
  assign monitor2_level_select = lvl2_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lvl1_r   <= LVL1_RST;
      lvl2_r   <= LVL2_RST;
      det_en_r <= 2'h0;
    end else begin
      if (wr_level) begin
        // codes past the ninth level are refused, field keeps its value
        if (lvl1_wd < MON1_LEVELS) begin
          lvl1_r <= lvl1_wd;
        end
        lvl2_r <= avs_writedata[LVL2_LSB +: 2];
      end
      if (wr_cmpctl) begin
        det_en_r <= avs_writedata[1:0];
      end
    end
  end

  // monitors 1 and 2
  smrc_cr0_t  cr0_r [2];
  smrc_cr1_t  cr1_r [2];
  logic [1:0] chg_r;
  logic [1:0] prev_r;
  logic [1:0] below_g;
  logic [1:0] fall;
  logic [1:0] rise;
  logic [1:0] irq_evt;
  logic [1:0] nmi_evt;
  logic [1:0] rst_hold;
  logic [1:0] rst_trig;

  genvar g;
  for (g = 0; g < 2; g++) begin : g_mon
    localparam logic [3:0] A_CR0 = (g == 0) ? OFS_M1_CR0 : OFS_M2_CR0;
    localparam logic [3:0] A_CR1 = (g == 0) ? OFS_M1_CR1 : OFS_M2_CR1;
    localparam logic [3:0] A_SR  = (g == 0) ? OFS_M1_SR  : OFS_M2_SR;
    wire active  = det_en_r[g] & cr0_r[g].compare_enable;
    wire armed   = cr0_r[g].action_enable;
    wire rmode   = cr0_r[g].reset_or_irq;
    wire cond_ok = (fall[g] && cr1_r[g].irq_condition != COND_RISE) ||
                   (rise[g] && cr1_r[g].irq_condition != COND_FALL);
    wire clr_chg = wr_en && avs_address == A_SR && avs_writedata[SR_CHG];

    assign below_g[g]  = active & monitor_below[g];
    assign fall[g]     = below_g[g] & ~prev_r[g];
    assign rise[g]     = active & ~below_g[g] & prev_r[g];
    assign irq_evt[g]  = armed & ~rmode & cond_ok & ~cr1_r[g].irq_type;
    assign nmi_evt[g]  = armed & ~rmode & cond_ok & cr1_r[g].irq_type;
    // release after recovery keeps the hold; release after drop only triggers
    assign rst_hold[g] = armed & rmode & ~cr0_r[g].release_select & below_g[g];
    assign rst_trig[g] = armed & rmode & fall[g];

    assign rmap[A_CR0] = {28'h000_0000, cr0_r[g]};
    assign rmap[A_CR1] = {29'h0000_0000, cr1_r[g]};
    assign rmap[A_SR]  = {30'h0000_0000, ~monitor_below[g], chg_r[g]};

    // gating and routing of this monitor
    chk_action_gate: assert property (@(posedge clock) disable iff (!rst_n)
      !armed |-> (irq_evt[g] | nmi_evt[g] | rst_trig[g] | rst_hold[g]) == 1'b0)
      else $error("disabled monitor acted");
    chk_compare_gate: assert property (@(posedge clock) disable iff (!rst_n)
      !active |-> (fall[g] | rise[g]) == 1'b0)
      else $error("gated comparator gave a crossing");
    chk_cond_fall: assert property (@(posedge clock) disable iff (!rst_n)
      irq_evt[g] && cr1_r[g].irq_condition == COND_FALL |-> fall[g])
      else $error("falling-only interrupt on a rise");
    chk_mode_irq: assert property (@(posedge clock) disable iff (!rst_n)
      !rmode |-> (rst_trig[g] | rst_hold[g]) == 1'b0)
      else $error("interrupt mode produced a reset");
    chk_event_crossing: assert property (@(posedge clock) disable iff (!rst_n)
      (irq_evt[g] | nmi_evt[g]) |-> (fall[g] | rise[g]))
      else $error("interrupt without a crossing");
    chk_change_clear: assert property (@(posedge clock) disable iff (!rst_n)
      clr_chg && !fall[g] && !rise[g] |=> !chg_r[g])
      else $error("change flag not cleared");

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        cr0_r[g]  <= '0;
        cr1_r[g]  <= '0;
        chg_r[g]  <= 1'b0;
        prev_r[g] <= 1'b0;
      end else begin
        prev_r[g] <= below_g[g];
        // a crossing in the clearing cycle still leaves the flag set
        chg_r[g]  <= (chg_r[g] & ~clr_chg) | fall[g] | rise[g];
        if (wr_en && avs_address == A_CR0) begin
          cr0_r[g] <= smrc_cr0_t'(avs_writedata[3:0]);
        end
        if (wr_en && avs_address == A_CR1) begin
          cr1_r[g] <= smrc_cr1_t'(avs_writedata[2:0]);
        end
      end
    end
  end

  // reset generation
  logic [CNT_W-1:0] rel_cnt_r;
  logic             chip_reset_r;
  logic             m0_prev_r;
  wire              wdt_evt  = watchdog_underflow | watchdog_refresh_error;
  wire              src_hold = monitor0_below | (|rst_hold);
  wire              src_trig = (|rst_trig) | wdt_evt | wr_swreset;
  wire [CNT_W-1:0]  rel_cnt_nxt = (src_hold | src_trig) ? CNT_W'(RELEASE_COUNT) :
                                  (rel_cnt_r != '0) ? rel_cnt_r - 1'b1 : rel_cnt_r;
  assign chip_reset = chip_reset_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rel_cnt_r    <= CNT_W'(RELEASE_COUNT);
      chip_reset_r <= 1'b1;
      m0_prev_r    <= 1'b0;
    end else begin
      rel_cnt_r    <= rel_cnt_nxt;
      chip_reset_r <= rel_cnt_nxt != '0;
      m0_prev_r    <= monitor0_below;
    end
  end

  // cause flags; power-on reset clears all but the power-on flag, which it sets, and writing ones also clears the cause A and C flags
  logic [3:0] cause_a_r;
  logic       cws_r;
  logic [1:0] cause_c_r;
  wire  [3:0] set_a = {rst_trig[1], rst_trig[0], monitor0_below & ~m0_prev_r, 1'b0};
  wire  [1:0] set_c = {wr_swreset, wdt_evt};
  wire  [3:0] clr_a = wr_cause_a ? avs_writedata[3:0] : 4'h0;
  wire  [1:0] clr_c = wr_cause_c ? avs_writedata[1:0] : 2'h0;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cause_a_r <= CAUSE_A_RST;
      cws_r     <= 1'b0;
      cause_c_r <= 2'h0;
    end else begin
      cause_a_r <= (cause_a_r & ~clr_a) | set_a;
      cause_c_r <= (cause_c_r & ~clr_c) | set_c;
      // software marks warm; only power-on returns it to cold
      if (wr_cause_b && avs_writedata[CB_CWS]) begin
        cws_r <= 1'b1;
      end
    end
  end

  // interrupts
  logic [1:0] irq_st_r;
  logic [1:0] irq_en_r;
  logic       nmi_r;
  wire  [1:0] irq_clr = wr_irq_clr ? avs_writedata[1:0] : 2'h0;
  assign irq     = |(irq_st_r & irq_en_r);
  assign nmi_req = nmi_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_r <= 2'h0;
      irq_en_r <= 2'h0;
      nmi_r    <= 1'b0;
    end else begin
      irq_st_r <= (irq_st_r & ~irq_clr) | irq_evt;
      nmi_r    <= |nmi_evt;
      if (wr_irq_en) begin
        irq_en_r <= avs_writedata[1:0];
      end
    end
  end

  // read map
  assign rmap[OFS_CAUSE_A]  = {28'h000_0000, cause_a_r};
  assign rmap[OFS_CAUSE_B]  = {31'h0000_0000, cws_r};
  assign rmap[OFS_CAUSE_C]  = {30'h0000_0000, cause_c_r};
  assign rmap[OFS_SWRESET]  = 32'h0000_0000;
  assign rmap[OFS_LEVEL]    = {26'h000_0000, lvl2_r, lvl1_r};
  assign rmap[OFS_CMPCTL]   = {30'h0000_0000, det_en_r};
  assign rmap[OFS_IRQ_STAT] = {30'h0000_0000, irq_st_r};
  assign rmap[OFS_IRQ_CLR]  = 32'h0000_0000;
  assign rmap[OFS_IRQ_EN]   = {30'h0000_0000, irq_en_r};
  assign rmap[4'hF]         = 32'h0000_0000;

  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_sw_write;
    wr_swreset;
  endsequence

  sequence s_reset_marked;
    chip_reset && cause_c_r[CC_SW];
  endsequence

  sequence s_nmi_event;
    nmi_evt != 2'h0;
  endsequence

  sequence s_count_reloaded;
    rel_cnt_r == CNT_W'(RELEASE_COUNT);
  endsequence

  sequence s_reset_drop;
    rst_trig != 2'h0;
  endsequence

  sequence s_m0_recovered;
    !monitor0_below && m0_prev_r;
  endsequence

  sequence s_bad_level;
    wr_level && lvl1_wd >= MON1_LEVELS;
  endsequence

  chk_mon0_hold: assert property (monitor0_below |=> chip_reset)
    else $error("monitor 0 low without chip reset");
  chk_release_end: assert property (!src_hold && !src_trig && rel_cnt_r == CNT_W'(1) |=> !chip_reset)
    else $error("chip reset not released after delay");
  chk_level_range: assert property (lvl1_r < MON1_LEVELS)
    else $error("monitor 1 level out of range");
  chk_change_flag: assert property (|(fall | rise) |=> (chg_r & $past(fall | rise)) != 2'h0)
    else $error("crossing did not set change flag");
  chk_disabled_quiet: assert property (det_en_r == 2'h0 |-> (fall | rise) == 2'h0)
    else $error("disabled detector produced a crossing");
  chk_nmi_route: assert property (nmi_req |-> $past(|nmi_evt) && (irq_st_r & $past(nmi_evt & ~irq_st_r)) == 2'h0)
    else $error("nmi raised without nmi routing");
  chk_cond_rise: assert property (irq_evt[0] && cr1_r[0].irq_condition == COND_RISE |-> rise[0])
    else $error("interrupt on wrong crossing");
  chk_reset_mode: assert property (rst_trig != 2'h0 |=> chip_reset && (cause_a_r[CA_M2:CA_M1] != 2'h0))
    else $error("reset mode did not reset");
  chk_sw_reset: assert property (s_sw_write |=> s_reset_marked)
    else $error("software reset not applied");
  chk_wdt_cause: assert property (wdt_evt |=> ##[0:1] cause_c_r[CC_WDT] && chip_reset)
    else $error("watchdog reset not recorded");
  chk_cause_sticky: assert property (cause_a_r[CA_M0] && !wr_cause_a |=> cause_a_r[CA_M0])
    else $error("cause flag lost without clear");
  chk_strap_held: assert property (strap_done_r |=> $stable(m0_lvl_r))
    else $error("monitor 0 level changed after capture");
  chk_level_refused: assert property (s_bad_level |=> $stable(lvl1_r))
    else $error("illegal monitor 1 level accepted");
  chk_level_written: assert property (wr_level && lvl1_wd < MON1_LEVELS |=> lvl1_r == $past(lvl1_wd))
    else $error("legal monitor 1 level not taken");
  chk_level2_written: assert property (wr_level |=> lvl2_r == $past(avs_writedata[LVL2_LSB +: 2]))
    else $error("monitor 2 level not taken");
  chk_m0_cause: assert property (monitor0_below && !m0_prev_r |=> cause_a_r[CA_M0])
    else $error("monitor 0 cause not recorded");
  chk_m0_recovery: assert property (s_m0_recovered |-> chip_reset ##0 s_count_reloaded)
    else $error("monitor 0 delay not started at recovery");
  chk_por_sticky: assert property (cause_a_r[CA_POR] && !clr_a[CA_POR] |=> cause_a_r[CA_POR])
    else $error("power-on flag lost without clear");
  chk_warm_sticky: assert property (cws_r |=> cws_r)
    else $error("warm start flag lost");
  chk_sw_reload: assert property (s_sw_write |=> s_count_reloaded)
    else $error("software reset did not restart delay");
  chk_wdt_reload: assert property (wdt_evt |=> s_count_reloaded)
    else $error("watchdog reset did not restart delay");
  chk_drop_reload: assert property (s_reset_drop |=> s_count_reloaded)
    else $error("drop did not restart delay");
  chk_hold_below: assert property (rst_hold != 2'h0 |=> chip_reset)
    else $error("reset not held while below");
  chk_irq_status: assert property (irq_evt != 2'h0 |=> (irq_st_r & $past(irq_evt)) == $past(irq_evt))
    else $error("interrupt event not recorded");
  chk_nmi_pulse: assert property (s_nmi_event |=> nmi_req)
    else $error("nmi event without nmi request");
  chk_cause_clear: assert property (wr_cause_c && avs_writedata[CC_SW] |=> !cause_c_r[CC_SW])
    else $error("software cause flag not cleared");
  chk_one_wait: assert property (bus_acc && !ack_r |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus access not answered after one wait");

endmodule

// ### verif/smrc_supply_model.sv
`timescale 1ns/10ps
module smrc_supply_model #(
  parameter int TH0_LO  = 1500,
  parameter int TH0_HI  = 1700,
  parameter int TH1_TOP = 4000,
  parameter int TH2_TOP = 3500
) (
  // supply set by the bench, in millivolts
  input  wire logic        clock,
  input  wire logic [15:0] vcc_mv,
  // levels chosen by the block
  input  wire logic [1:0]  lvl0,
  input  wire logic [3:0]  lvl1,
  input  wire logic [1:0]  lvl2,
  // comparator results
  output logic             below0 = 1'b0,
  output logic [1:0]       below12 = 2'h0
);
  // result lags the supply by one edge, like a real comparator
  always @(posedge clock) begin
    below0     <= int'(vcc_mv) < ((lvl0 == 2'h0) ? TH0_LO : TH0_HI);
    below12[0] <= int'(vcc_mv) < (TH1_TOP - 100 * int'(lvl1));
    below12[1] <= int'(vcc_mv) < (TH2_TOP - 200 * int'(lvl2));
  end
endmodule

// ### verif/tb.sv
`timescale 1ns/10ps
module tb
  import smrc_pkg::*;
;
  typedef struct packed {logic [3:0] a; logic [31:0] d; logic [31:0] e;} smrc_row_t;
  localparam int RC = 8;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [31:0] got;
  logic        wait_req;
  logic        uf = 1'b0;
  logic        rfe = 1'b0;
  logic [15:0] vcc = 16'h1388;
  logic        below0;
  logic [1:0]  below12;
  logic [1:0]  lvl0;
  logic [3:0]  lvl1;
  logic [1:0]  lvl2;
  logic        crst;
  logic        nmi;
  logic        irq;
  int          err_total = 0;
  int          n_checks = 0;
  int          nmi_cnt = 0;
  smrc_row_t   rows [8] = '{
    '{OFS_LEVEL, 32'h0000_0015, 32'h0000_0015},
    '{OFS_LEVEL, 32'h0000_001F, 32'h0000_0015},
    '{OFS_CMPCTL, 32'h0000_0003, 32'h0000_0003},
    '{OFS_M1_CR0, 32'h0000_0003, 32'h0000_0003},
    '{OFS_M1_CR1, 32'h0000_0001, 32'h0000_0001},
    '{OFS_M2_CR0, 32'h0000_0000, 32'h0000_0000},
    '{OFS_IRQ_EN, 32'h0000_0003, 32'h0000_0003},
    '{4'hF, 32'h0000_FFFF, 32'h0000_0000}};

  always #2.5 clock = ~clock;
  always @(posedge clock) if (nmi === 1'b1) nmi_cnt <= nmi_cnt + 1;

  smrc_top #(.RELEASE_COUNT(RC)) DUT (
    .clock(clock), .rst_n(rst_n), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wait_req),
    .monitor0_level_select(2'h1), .monitor0_below(below0), .monitor_below(below12),
    .watchdog_underflow(uf), .watchdog_refresh_error(rfe), .monitor0_level(lvl0),
    .monitor1_level_select(lvl1), .monitor2_level_select(lvl2), .chip_reset(crst),
    .nmi_req(nmi), .irq(irq));
  smrc_supply_model SUP (
    .clock(clock), .vcc_mv(vcc), .lvl0(lvl0), .lvl1(lvl1), .lvl2(lvl2),
    .below0(below0), .below12(below12));

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask

  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    @(posedge clock);
    while (wait_req !== 1'b0) begin
      @(posedge clock);
    end
    got = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(got, e, "read");
  endtask

  task automatic wait_rst(input logic v, input int n);
    int k;
    k = 0;
    while (crst !== v && k < n) begin
      k++;
      @(posedge clock);
    end
    chk({31'h0, crst}, {31'h0, v}, "chip reset");
  endtask

  task automatic vset(input logic [15:0] v);
    vcc <= v;
    repeat (4) @(posedge clock);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #50000;
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge clock);
    chk({31'h0, crst}, 32'h0000_0001, "reset held");
    rst_n <= 1'b1;
    wait_rst(1'b0, RC + 6);
    chk({30'h0, lvl0}, 32'h0000_0001, "strap");
    rchk(OFS_CAUSE_A, 32'h0000_0001);
    rchk(OFS_CAUSE_B, 32'h0000_0000);
    $display("reset test done");
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e);
    end
    chk({28'h0, lvl1}, 32'h0000_0005, "lvl1");
    chk({30'h0, lvl2}, 32'h0000_0001, "lvl2");
    $display("register table done");
    vset(16'h0D48);
    chk({31'h0, irq}, 32'h0000_0001, "irq on fall");
    rchk(OFS_IRQ_STAT, 32'h0000_0001);
    rchk(OFS_M1_SR, 32'h0000_0001);
    bus(1'b1, OFS_IRQ_CLR, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
    vset(16'h1388);
    chk({31'h0, irq}, 32'h0000_0000, "rise ignored");
    rchk(OFS_M1_SR, 32'h0000_0003);
    bus(1'b1, OFS_IRQ_EN, 32'h0000_0000);
    vset(16'h0D48);
    rchk(OFS_IRQ_STAT, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000, "masked");
    bus(1'b1, OFS_IRQ_CLR, 32'h0000_0001);
    bus(1'b1, OFS_IRQ_EN, 32'h0000_0003);
    bus(1'b1, OFS_M1_CR1, 32'h0000_0004);
    vset(16'h1388);
    chk(nmi_cnt, 32'h0000_0001, "nmi");
    chk({31'h0, irq}, 32'h0000_0000, "nmi not irq");
    bus(1'b1, OFS_M1_SR, 32'h0000_0001);
    bus(1'b1, OFS_M1_CR0, 32'h0000_0001);
    vset(16'h0D48);
    vset(16'h1388);
    chk(nmi_cnt, 32'h0000_0001, "compare gated");
    rchk(OFS_M1_SR, 32'h0000_0002);
    bus(1'b1, OFS_M1_CR0, 32'h0000_0003);
    bus(1'b1, OFS_CMPCTL, 32'h0000_0002);
    vset(16'h0D48);
    chk(nmi_cnt, 32'h0000_0001, "detector off");
    vset(16'h1388);
    bus(1'b1, OFS_CMPCTL, 32'h0000_0003);
    bus(1'b1, OFS_M1_CR1, 32'h0000_0002);
    vset(16'h0D48);
    chk({31'h0, irq}, 32'h0000_0000, "fall ignored");
    vset(16'h1388);
    chk({31'h0, irq}, 32'h0000_0001, "irq on rise");
    bus(1'b1, OFS_IRQ_CLR, 32'h0000_0001);
    $display("interrupt tests done");
    // release counted from the drop while supply stays low
    bus(1'b1, OFS_M1_CR0, 32'h0000_000F);
    vset(16'h0D48);
    chk({31'h0, crst}, 32'h0000_0001, "m1 reset");
    wait_rst(1'b0, 14);
    vset(16'h1388);
    chk(nmi_cnt, 32'h0000_0001, "reset mode no nmi");
    bus(1'b1, OFS_M1_CR0, 32'h0000_0000);
    bus(1'b1, OFS_M2_CR0, 32'h0000_0007);
    vset(16'h0C80);
    repeat (20) @(posedge clock);
    chk({31'h0, crst}, 32'h0000_0001, "m2 held");
    vset(16'h1388);
    chk({31'h0, crst}, 32'h0000_0001, "m2 delay");
    wait_rst(1'b0, 14);
    rchk(OFS_CAUSE_A, 32'h0000_000D);
    bus(1'b1, OFS_CAUSE_A, 32'h0000_000F);
    rchk(OFS_CAUSE_A, 32'h0000_0000);
    bus(1'b1, OFS_M2_CR0, 32'h0000_0000);
    vset(16'h03E8);
    repeat (20) @(posedge clock);
    chk({31'h0, crst}, 32'h0000_0001, "m0 held");
    vset(16'h1388);
    chk({31'h0, crst}, 32'h0000_0001, "m0 delay");
    wait_rst(1'b0, 14);
    rchk(OFS_CAUSE_A, 32'h0000_0002);
    $display("monitor reset tests done");
    bus(1'b1, OFS_CAUSE_B, 32'h0000_0001);
    bus(1'b1, OFS_SWRESET, 32'h0000_1234);
    wait_rst(1'b1, 4);
    wait_rst(1'b0, 16);
    rchk(OFS_CAUSE_C, 32'h0000_0002);
    rchk(OFS_CAUSE_B, 32'h0000_0001);
    bus(1'b1, OFS_CAUSE_C, 32'h0000_0003);
    uf <= 1'b1;
    @(posedge clock);
    uf <= 1'b0;
    wait_rst(1'b1, 4);
    wait_rst(1'b0, 16);
    rchk(OFS_CAUSE_C, 32'h0000_0001);
    bus(1'b1, OFS_CAUSE_C, 32'h0000_0001);
    rfe <= 1'b1;
    @(posedge clock);
    rfe <= 1'b0;
    wait_rst(1'b1, 4);
    wait_rst(1'b0, 16);
    rchk(OFS_CAUSE_C, 32'h0000_0001);
    $display("software and watchdog done");
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    wait_rst(1'b0, RC + 6);
    rchk(OFS_CAUSE_A, 32'h0000_0001);
    rchk(OFS_CAUSE_B, 32'h0000_0000);
    rchk(OFS_LEVEL, 32'h0000_0000);
    $display("second power-on done");
    end_of_test();
  end
endmodule
